// ===== verilog/reset_sequencer.sv
// Reset sequencer: pin qualification, release delay, vector fetch,
// register defaults, watchdog preset and oscillator start-up.
// Assumes core_clk is the main oscillator and rst is the power-on reset.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Reset pin low 2 us with a stable clock enters internal reset.
// - After pin release, internal reset stays for about 8200 clock cycles.
// - Program counter loads high byte from FFFD, low byte from FFFC.
// - Reset sets the interrupt-disable bit of the status register.
// - Watchdog upper counter presets to 3F, lower counter to FF.
// - Watchdog control register resets to low six bits one.
// - Processor mode register resets to 0100_1000.
// - Converter control register resets with only bit 3 set.
// - Tone timers reset to 06, tone high byte to 00.
// - Only main oscillator runs at power-on; sub-clock pins stay undriven.
// - After reset the system clock is the main clock divided by 8.
// - Watchdog holds 3FFF and stays stopped until its control is written.
module reset_sequencer #(
  parameter int RELEASE_CYCLES = rst_seq_pkg::RELEASE_CYCLES_DEF,
  parameter int LOW_CYCLES = rst_seq_pkg::RST_LOW_CYCLES
) (
  // Clock and power-on reset.
  input wire logic core_clk,
  input wire logic rst,
  // Reset pin, active low.
  input wire logic reset_in_n,
  // Oscillator pins.
  input wire logic sub_osc_in,
  output logic main_osc_run_q,
  output logic sub_osc_out_q,
  output logic sub_osc_out_oe_q,
  output logic sub_osc_in_oe_q,
  // Core control.
  output logic int_rst_q,
  output logic cpu_run_q,
  output logic sys_clk_en_q,
  output logic [7:0] proc_status_reg_q,
  output logic [7:0] prog_counter_high_q,
  output logic [7:0] prog_counter_low_q,
  // Vector fetch from program memory.
  output logic vec_rd_q,
  output logic [15:0] vec_addr_q,
  input wire logic [7:0] vec_rdata,
  // Watchdog.
  output logic [5:0] wdt_high_q,
  output logic [7:0] wdt_low_q,
  output logic wdt_run_q,
  // Register port.
  input wire logic [rst_seq_pkg::REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import rst_seq_pkg::*;

  localparam int DLY_W = $clog2(RELEASE_CYCLES + 1);
  localparam int LOW_W = $clog2(LOW_CYCLES + 1);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(RELEASE_CYCLES - 1);
  localparam logic [LOW_W-1:0] LOW_LAST = LOW_W'(LOW_CYCLES - 1);
  localparam logic [2:0] DIV_LAST = 3'(SYS_DIV - 1);
  localparam logic [REG_AW-1:0] INIT_LAST = REG_AW'(REG_DEPTH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic rst_pin_s1_q;
  logic rst_pin_s2_q;
  logic sub_in_s1_q;
  logic sub_in_s2_q;

  // The pin idles high, so the synchroniser clears high and shows no false low.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rst_pin_s1_q <= 1'b1;
      rst_pin_s2_q <= 1'b1;
    end else begin
      rst_pin_s1_q <= reset_in_n;
      rst_pin_s2_q <= rst_pin_s1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sub_in_s1_q <= 1'b0;
      sub_in_s2_q <= 1'b0;
    end else begin
      sub_in_s1_q <= sub_osc_in;
      sub_in_s2_q <= sub_in_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin low-time qualification.

  logic [LOW_W-1:0] low_cnt_q;
  logic pin_reset;

  // The pin only counts as a reset once it has stayed low long enough.
  assign pin_reset = !rst_pin_s2_q && (low_cnt_q == LOW_LAST);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_cnt_q <= '0;
    end else if (rst_pin_s2_q) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != LOW_LAST) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register store and default loading.

  reg_store_if rs ();

  reg_store #(
    .DEPTH(REG_DEPTH)
  ) u_store (
    .core_clk(core_clk),
    .bus(rs)
  );

  logic init_busy_q;
  logic [REG_AW-1:0] init_ptr_q;
  logic [8:0] init_val;
  seq_state_t state_q;
  logic wdt_reset;
  logic sw_wr;

  assign init_val = reset_default(init_ptr_q);
  // Software writes are ignored while the core is held in reset.
  assign sw_wr = reg_wr && cpu_run_q;

  // Walk every slot once per reset and load the defined defaults.
  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || wdt_reset) begin
      init_busy_q <= 1'b1;
      init_ptr_q <= '0;
    end else if (init_busy_q) begin
      init_ptr_q <= init_ptr_q + 1'b1;
      if (init_ptr_q == INIT_LAST) begin
        init_busy_q <= 1'b0;
      end
    end
  end

  // Slots without a defined value keep their old contents.
  always_comb begin
    if (init_busy_q) begin
      rs.we = init_val[8];
      rs.waddr = init_ptr_q;
      rs.wdata = init_val[7:0];
    end else begin
      rs.we = sw_wr;
      rs.waddr = reg_addr;
      rs.wdata = reg_wdata;
    end
  end

  assign rs.raddr = reg_addr;
  assign rs.re = reg_rd;
  assign rs.wdt_high = wdt_high_q;
  assign reg_rdata = rs.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state machine.

  logic [DLY_W-1:0] dly_cnt_q;

  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || wdt_reset) begin
      state_q <= ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: begin
          if (rst_pin_s2_q && !init_busy_q) begin
            state_q <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (rst_pin_s2_q && dly_cnt_q == DLY_LAST) begin
            state_q <= ST_FETCH_LO;
          end
        end
        ST_FETCH_LO: state_q <= ST_FETCH_HI;
        ST_FETCH_HI: state_q <= ST_LOAD;
        ST_LOAD: state_q <= ST_RUN;
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_RESET;
      endcase
    end
  end

  // A low sample on the pin during the delay starts it again.
  always_ff @(posedge core_clk) begin
    if (rst || state_q != ST_DELAY || !rst_pin_s2_q) begin
      dly_cnt_q <= '0;
    end else if (dly_cnt_q != DLY_LAST) begin
      dly_cnt_q <= dly_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_rst_q <= 1'b1;
    end else if (pin_reset || wdt_reset) begin
      int_rst_q <= 1'b1;
    end else if (state_q == ST_DELAY && rst_pin_s2_q && dly_cnt_q == DLY_LAST) begin
      int_rst_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || wdt_reset) begin
      cpu_run_q <= 1'b0;
    end else if (state_q == ST_LOAD) begin
      cpu_run_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset vector fetch and status register.

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vec_rd_q <= 1'b0;
      vec_addr_q <= VEC_LO_ADDR;
    end else if (state_q == ST_DELAY && rst_pin_s2_q && dly_cnt_q == DLY_LAST) begin
      vec_rd_q <= 1'b1;
      vec_addr_q <= VEC_LO_ADDR;
    end else if (state_q == ST_FETCH_LO) begin
      vec_rd_q <= 1'b1;
      vec_addr_q <= VEC_HI_ADDR;
    end else begin
      vec_rd_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prog_counter_low_q <= '0;
      prog_counter_high_q <= '0;
    end else if (state_q == ST_FETCH_HI) begin
      prog_counter_low_q <= vec_rdata;
    end else if (state_q == ST_LOAD) begin
      prog_counter_high_q <= vec_rdata;
    end
  end

  // Only the interrupt-disable bit has a defined value; the rest read zero.
  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || wdt_reset) begin
      proc_status_reg_q <= PS_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock enable in middle-speed mode.

  logic [2:0] div_cnt_q;

  always_ff @(posedge core_clk) begin
    // Also cleared on the entering edge, so no pulse stands beside internal reset.
    if (rst || int_rst_q || pin_reset || wdt_reset) begin
      div_cnt_q <= '0;
      sys_clk_en_q <= 1'b0;
    end else begin
      div_cnt_q <= (div_cnt_q == DIV_LAST) ? 3'b000 : div_cnt_q + 1'b1;
      sys_clk_en_q <= (div_cnt_q == DIV_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog preset and run control.

  logic wdt_ctrl_wr;
  logic wdt_zero;

  assign wdt_ctrl_wr = sw_wr && reg_addr == WDT_CTRL_ADDR;
  assign wdt_zero = {wdt_high_q, wdt_low_q} == WDT_ZERO;
  // An underflow of a running watchdog throws the device back into reset.
  assign wdt_reset = wdt_run_q && sys_clk_en_q && wdt_zero && !wdt_ctrl_wr;

  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || wdt_reset) begin
      wdt_run_q <= 1'b0;
    end else if (wdt_ctrl_wr) begin
      wdt_run_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || wdt_reset || wdt_ctrl_wr) begin
      wdt_high_q <= WDT_HIGH_RESET;
      wdt_low_q <= WDT_LOW_RESET;
    end else if (wdt_run_q && sys_clk_en_q) begin
      {wdt_high_q, wdt_low_q} <= {wdt_high_q, wdt_low_q} - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator start-up.

  logic sub_en_q;

  always_ff @(posedge core_clk) begin
    if (rst || pin_reset || wdt_reset) begin
      sub_en_q <= 1'b0;
    end else if (sw_wr && reg_addr == CPU_MODE_ADDR) begin
      sub_en_q <= reg_wdata[SUBCLK_EN_BIT];
    end
  end

  // Only the main oscillator runs from power-on onward.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      main_osc_run_q <= 1'b0;
    end else begin
      main_osc_run_q <= 1'b1;
    end
  end

  // The sub-clock output pin stays undriven until software enables the sub-clock; the input pin is never driven.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sub_osc_out_q <= 1'b0;
      sub_osc_out_oe_q <= 1'b0;
      sub_osc_in_oe_q <= 1'b0;
    end else begin
      sub_osc_out_q <= sub_en_q && !sub_in_s2_q;
      sub_osc_out_oe_q <= sub_en_q;
      sub_osc_in_oe_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/rst_seq_pkg.sv
// Constants and reset defaults for the reset sequencer.
// Assumes a single 40 MHz core clock standing for the main oscillator input.
`default_nettype none
package rst_seq_pkg;

  localparam int CLK_PERIOD_NS = 25;
  // The reset pin must stay low at least this long to be taken.
  localparam int RST_LOW_MIN_NS = 2000;
  localparam int RST_LOW_CYCLES = (RST_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // The release delay in main oscillator cycles.
  localparam int RELEASE_CYCLES_DEF = 8200;
  // Middle-speed mode divides the main oscillator by this.
  localparam int SYS_DIV = 8;

  localparam int REG_AW = 6;
  localparam int REG_DEPTH = 64;

  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFC;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFD;
  localparam logic [5:0] WDT_CTRL_ADDR = 6'h37;
  localparam logic [5:0] CPU_MODE_ADDR = 6'h3B;
  localparam int SUBCLK_EN_BIT = 4;
  localparam int WDT_CTRL_KEEP_LSB = 6;
  localparam logic [7:0] PS_RESET = 8'h04;
  localparam logic [5:0] WDT_HIGH_RESET = 6'h3F;
  localparam logic [7:0] WDT_LOW_RESET = 8'hFF;
  localparam logic [13:0] WDT_ZERO = 14'h0000;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_DELAY = 3'b001,
    ST_FETCH_LO = 3'b010,
    ST_FETCH_HI = 3'b011,
    ST_LOAD = 3'b100,
    ST_RUN = 3'b101
  } seq_state_t;

  // Reset value of each register slot; bit 8 tells whether it has one.
  function automatic logic [8:0] reset_default(input logic [5:0] addr);
    case (addr)
      6'h01, 6'h03, 6'h05, 6'h07, 6'h09, 6'h0B, 6'h0D, 6'h0F: reset_default = 9'h100;
      6'h14: reset_default = 9'h101;
      6'h15: reset_default = 9'h100;
      6'h16: reset_default = 9'h13F;
      6'h17: reset_default = 9'h100;
      6'h19: reset_default = 9'h180;
      6'h1A: reset_default = 9'h100;
      6'h1B: reset_default = 9'h1C0;
      6'h1D: reset_default = 9'h100;
      6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h26: reset_default = 9'h1FF;
      6'h25: reset_default = 9'h101;
      6'h27, 6'h28, 6'h29, 6'h2A, 6'h2B: reset_default = 9'h100;
      6'h2E, 6'h30, 6'h31: reset_default = 9'h106;
      6'h2F, 6'h32, 6'h33: reset_default = 9'h100;
      6'h34: reset_default = 9'h108;
      6'h36: reset_default = 9'h100;
      6'h37: reset_default = 9'h13F;
      6'h38, 6'h39, 6'h3A: reset_default = 9'h100;
      6'h3B: reset_default = 9'h148;
      6'h3C, 6'h3D, 6'h3E, 6'h3F: reset_default = 9'h100;
      default: reset_default = 9'h000;
    endcase
  endfunction

endpackage
`default_nettype wire

// ===== verilog/reg_store_if.sv
// Carrier between the sequencer and its register store.
// Assumes both ends run on core_clk.
`timescale 1ns/100ps
`default_nettype none
interface reg_store_if;
  logic we;
  logic re;
  logic [5:0] waddr;
  logic [7:0] wdata;
  logic [5:0] raddr;
  logic [5:0] wdt_high;
  logic [7:0] rdata;
  modport owner (output we, output re, output waddr, output wdata, output raddr,
    output wdt_high, input rdata);
  modport store (input we, input re, input waddr, input wdata, input raddr,
    input wdt_high, output rdata);
endinterface
`default_nettype wire

// ===== verilog/reg_store.sv
// Register store: 64 bytes, one write port, registered read.
// Assumes the owner holds the address for one cycle per read.
`timescale 1ns/100ps
`default_nettype none
module reg_store #(
  parameter int DEPTH = rst_seq_pkg::REG_DEPTH
) (
  // Clock.
  input wire logic core_clk,
  // Owner side.
  reg_store_if.store bus
);
  import rst_seq_pkg::*;

  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_q;

  always_ff @(posedge core_clk) begin
    if (bus.we) begin
      mem_q[bus.waddr] <= bus.wdata;
    end
  end

  // The watchdog control slot reads back the live upper counter.
  // Read data are taken on a read strobe and held until the next one.
  always_ff @(posedge core_clk) begin
    if (bus.re && bus.raddr == WDT_CTRL_ADDR) begin
      rdata_q <= {mem_q[bus.raddr][7:WDT_CTRL_KEEP_LSB], bus.wdt_high};
    end else if (bus.re) begin
      rdata_q <= mem_q[bus.raddr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule
`default_nettype wire

// ===== bench/reset_sequencer_props.sv
// Concurrent checks on the reset sequencer's top-level ports.
// Assumes one clock domain and a synchronous active-high rst.
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer_props #(
  parameter int RELEASE_CYCLES = 20,
  parameter int LOW_CYCLES = 4
) (
  // Clock, power-on reset and reset pin.
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_in_n,
  // Oscillator and core state.
  input wire logic main_osc_run_q,
  input wire logic sub_osc_out_oe_q,
  input wire logic sub_osc_in_oe_q,
  input wire logic int_rst_q,
  input wire logic cpu_run_q,
  input wire logic sys_clk_en_q,
  input wire logic [7:0] proc_status_reg_q,
  input wire logic [7:0] prog_counter_high_q,
  input wire logic [7:0] prog_counter_low_q,
  // Vector fetch.
  input wire logic vec_rd_q,
  input wire logic [15:0] vec_addr_q,
  input wire logic [7:0] vec_rdata,
  // Watchdog and register port.
  input wire logic [5:0] wdt_high_q,
  input wire logic [7:0] wdt_low_q,
  input wire logic wdt_run_q,
  input wire logic [rst_seq_pkg::REG_AW-1:0] reg_addr,
  input wire logic reg_wr
);
  import rst_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Saturating counts of consecutive pin levels, ahead of the synchroniser.
  logic [7:0] low_cnt_q;
  logic [7:0] high_cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst || reset_in_n) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hFF) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst || !reset_in_n) begin
      high_cnt_q <= 8'h00;
    end else if (high_cnt_q != 8'hFF) begin
      high_cnt_q <= high_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_pin_enter: assert property (low_cnt_q >= LOW_CYCLES + 5 |-> int_rst_q)
    else $error("internal reset missing after long pin low");
  a_release_wait: assert property ($fell(int_rst_q) |-> high_cnt_q >= RELEASE_CYCLES)
    else $error("internal reset released too early");
  a_fetch_order: assert property ($fell(int_rst_q) |-> vec_rd_q && vec_addr_q == VEC_LO_ADDR
    ##1 vec_rd_q && vec_addr_q == VEC_HI_ADDR ##1 !vec_rd_q)
    else $error("vector fetch order wrong");
  a_vector_load: assert property ($fell(int_rst_q) ##2 1 |->
    prog_counter_low_q == $past(vec_rdata) ##1 prog_counter_high_q == $past(vec_rdata)
    ##1 cpu_run_q)
    else $error("program counter not loaded from vector");
  a_status_set: assert property (int_rst_q && $past(int_rst_q) |-> proc_status_reg_q[2])
    else $error("interrupt disable flag clear in reset");
  a_wdt_preset: assert property (int_rst_q && $past(int_rst_q) |-> wdt_high_q == WDT_HIGH_RESET
    && wdt_low_q == WDT_LOW_RESET && !wdt_run_q)
    else $error("watchdog not preset in reset");
  a_wdt_start: assert property ($rose(wdt_run_q) |-> $past(reg_wr) && $past(cpu_run_q)
    && $past(reg_addr) == WDT_CTRL_ADDR)
    else $error("watchdog started without control write");
  a_sys_div: assert property (disable iff (rst || int_rst_q)
    sys_clk_en_q |=> !sys_clk_en_q [*7] ##1 sys_clk_en_q)
    else $error("system clock enable not every eighth cycle");
  a_sys_quiet: assert property (int_rst_q |-> !sys_clk_en_q)
    else $error("system clock enable during reset");
  a_sub_off: assert property (int_rst_q && $past(int_rst_q, 3) |-> !sub_osc_out_oe_q
    && !sub_osc_in_oe_q)
    else $error("sub-clock pin driven in reset");
  a_main_osc: assert property (!$past(rst) |-> main_osc_run_q)
    else $error("main oscillator not running");

  c_release: cover property ($fell(int_rst_q));
  c_wdt_start: cover property ($rose(wdt_run_q));
  c_sub_on: cover property ($rose(sub_osc_out_oe_q));
endmodule

bind reset_sequencer reset_sequencer_props #(
  .RELEASE_CYCLES(RELEASE_CYCLES),
  .LOW_CYCLES(LOW_CYCLES)
) u_props (
  .core_clk(core_clk), .rst(rst), .reset_in_n(reset_in_n),
  .main_osc_run_q(main_osc_run_q), .sub_osc_out_oe_q(sub_osc_out_oe_q),
  .sub_osc_in_oe_q(sub_osc_in_oe_q), .int_rst_q(int_rst_q), .cpu_run_q(cpu_run_q),
  .sys_clk_en_q(sys_clk_en_q), .proc_status_reg_q(proc_status_reg_q),
  .prog_counter_high_q(prog_counter_high_q), .prog_counter_low_q(prog_counter_low_q),
  .vec_rd_q(vec_rd_q), .vec_addr_q(vec_addr_q), .vec_rdata(vec_rdata),
  .wdt_high_q(wdt_high_q), .wdt_low_q(wdt_low_q), .wdt_run_q(wdt_run_q),
  .reg_addr(reg_addr), .reg_wr(reg_wr)
);
`default_nettype wire

// ===== bench/reset_supervisor.sv
// External reset circuit and sub-clock crystal stand-in.
// Assumes the bench commands each low pulse with a one-cycle go strobe.
`timescale 1ns/100ps
`default_nettype none
module reset_supervisor (
  // Clock.
  input wire logic core_clk,
  // Command from the bench.
  input wire logic go,
  input wire logic [7:0] low_len,
  // Pins.
  output var logic reset_in_n,
  output var logic sub_osc_in
);
  logic [7:0] left_q = 8'h00;
  logic [4:0] xtal_q = 5'h00;

  // The pin rests high on its pull-up and is pulled low for the commanded span.
  always @(posedge core_clk) begin
    if (go) begin
      left_q <= low_len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  always_comb reset_in_n = (left_q == 8'h00);

  // The sub-clock pin sees a free-running crystal, never a driven clock.
  always @(posedge core_clk) begin
    xtal_q <= xtal_q + 5'h01;
  end
  always_comb sub_osc_in = xtal_q[4];
endmodule
`default_nettype wire

// ===== bench/reset_sequencer_with_defaults_bench.sv
// Self-checking bench for the reset sequencer.
// Assumes shortened release and pin-low counts and a bench program memory.
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer_with_defaults_bench;
  import rst_seq_pkg::*;
  localparam int REL = 20;
  localparam int LOW = 4;
  localparam logic [5:0] ADR [17] = '{6'h01, 6'h0F, 6'h16, 6'h17, 6'h1B, 6'h20, 6'h24,
    6'h25, 6'h26, 6'h2E, 6'h2F, 6'h30, 6'h34, 6'h37, 6'h39, 6'h3B, 6'h3F};
  localparam logic [7:0] VAL [17] = '{8'h00, 8'h00, 8'h3F, 8'h00, 8'hC0, 8'hFF, 8'hFF,
    8'h01, 8'hFF, 8'h06, 8'h00, 8'h06, 8'h08, 8'h3F, 8'h00, 8'h48, 8'h00};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic [7:0] low_len = 8'h00;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] vec_rdata = 8'h00;
  logic reset_in_n, sub_osc_in, main_osc_run_q, sub_osc_out_q, sub_osc_out_oe_q;
  logic sub_osc_in_oe_q, int_rst_q, cpu_run_q, sys_clk_en_q, vec_rd_q, wdt_run_q;
  logic [7:0] proc_status_reg_q, prog_counter_high_q, prog_counter_low_q;
  logic [7:0] wdt_low_q, reg_rdata, rd;
  logic [15:0] vec_addr_q;
  logic [5:0] wdt_high_q;
  int fail_count = 0;
  int comparisons = 0;
  int n;

  always #12.5 core_clk = ~core_clk;

  // Program memory: answers the cycle after a read, otherwise shows no stale byte.
  always @(posedge core_clk) begin
    vec_rdata <= vec_rd_q ? (vec_addr_q[0] ? 8'h12 : 8'h34) : ~vec_rdata;
  end

  reset_supervisor partner (.core_clk(core_clk), .go(go), .low_len(low_len),
    .reset_in_n(reset_in_n), .sub_osc_in(sub_osc_in));

  reset_sequencer #(.RELEASE_CYCLES(REL), .LOW_CYCLES(LOW)) dut (
    .core_clk(core_clk), .rst(rst), .reset_in_n(reset_in_n), .sub_osc_in(sub_osc_in),
    .main_osc_run_q(main_osc_run_q), .sub_osc_out_q(sub_osc_out_q),
    .sub_osc_out_oe_q(sub_osc_out_oe_q), .sub_osc_in_oe_q(sub_osc_in_oe_q),
    .int_rst_q(int_rst_q), .cpu_run_q(cpu_run_q), .sys_clk_en_q(sys_clk_en_q),
    .proc_status_reg_q(proc_status_reg_q), .prog_counter_high_q(prog_counter_high_q),
    .prog_counter_low_q(prog_counter_low_q), .vec_rd_q(vec_rd_q), .vec_addr_q(vec_addr_q),
    .vec_rdata(vec_rdata), .wdt_high_q(wdt_high_q), .wdt_low_q(wdt_low_q),
    .wdt_run_q(wdt_run_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pin_low(input logic [7:0] len);
    @(posedge core_clk);
    go <= 1'b1;
    low_len <= len;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (len + 2) @(posedge core_clk);
    #1;
  endtask

  // Counts cycles until the core may run; a hang counts as a mismatch.
  task automatic wait_run(output int cyc);
    cyc = 0;
    while (cpu_run_q !== 1'b1 && cyc < 3000) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    check("run_timeout", 1'b0, cyc >= 3000);
  endtask

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    wait_run(n);
    check("pc", 16'h1234, {prog_counter_high_q, prog_counter_low_q});
    check("status_i", 1'b1, proc_status_reg_q[2]);
    check("wdt", 16'h3FFF, {wdt_high_q, wdt_low_q});
    check("wdt_run", 1'b0, wdt_run_q);
    check("osc", 4'b1000, {main_osc_run_q, sub_osc_out_oe_q, sub_osc_in_oe_q, sub_osc_out_q});
    for (int i = 0; i < 17; i++) begin
      reg_read(ADR[i], rd);
      check("default", VAL[i], rd);
    end
    reg_write(6'h10, 8'h5A);
    reg_read(6'h10, rd);
    check("user_reg", 8'h5A, rd);
    reg_write(CPU_MODE_ADDR, 8'h58);
    repeat (4) @(posedge core_clk);
    #1;
    check("sub_oe", 1'b1, sub_osc_out_oe_q);
    rd[0] = sub_osc_out_q;
    repeat (16) @(posedge core_clk);
    #1;
    check("sub_out", !rd[0], sub_osc_out_q);
    pin_low(8'd2);
    check("short_pin", 1'b0, int_rst_q);
    reg_write(WDT_CTRL_ADDR, 8'h00);
    #1;
    check("wdt_start", 1'b1, wdt_run_q);
    repeat (40) @(posedge core_clk);
    reg_read(WDT_CTRL_ADDR, rd);
    check("wdt_read", 8'h3F, rd);
    check("wdt_moving", 1'b1, wdt_low_q < 8'hFF);
    pin_low(8'd10);
    repeat (2) @(posedge core_clk);
    #1;
    check("long_pin", 1'b1, int_rst_q);
    check("wdt_stop", 1'b0, wdt_run_q);
    reg_write(6'h10, 8'hA5);
    repeat (70) @(posedge core_clk);
    pin_low(8'd2);
    wait_run(n);
    check("delay", 1'b1, n >= REL);
    reg_read(6'h10, rd);
    check("kept_reg", 8'h5A, rd);
    reg_read(CPU_MODE_ADDR, rd);
    check("mode_reload", 8'h48, rd);
    check("sub_oe_off", 1'b0, sub_osc_out_oe_q);
    finish_test();
  end

  initial begin
    #500000;
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
